// ### core/dcc_top.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Channel-on bit gates all transfers
// - Size bit picks byte or word elements
// - Half bit moves block interrupt to midpoint
// - Dummy write to peripheral with RAM write
// - Address pattern: increment, fixed, peripheral indirect
// - Continuous modes restart, ping-pong alternates buffers
// - One-shot stops; ping-pong one block each
module dcc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xfer_trig,
  input  wire logic [15:0] per_index,
  output logic             ram_req,
  output logic             ram_we,
  output logic      [15:0] ram_addr,
  output logic      [1:0]  ram_be,
  output logic      [15:0] ram_wdata,
  input  wire logic [15:0] ram_rdata,
  input  wire logic        ram_ack,
  output logic             per_req,
  output logic             per_we,
  output logic      [15:0] per_addr,
  output logic      [1:0]  per_be,
  output logic      [15:0] per_wdata,
  input  wire logic [15:0] per_rdata,
  input  wire logic        per_ack,
  output logic             irq
);

  // Software registers
  logic [15:0] ctrl_q;   // Control word
  logic [15:0] buf_a_q;  // Buffer A start
  logic [15:0] buf_b_q;  // Buffer B start
  logic [15:0] periph_q; // Peripheral data address
  logic [15:0] len_q;    // Elements per block minus 1
  logic [15:0] ctrl_d;   // Next control word

  // Engine state
  dcc_pkg::dcc_state_t st_q;     // Current state
  dcc_pkg::dcc_state_t st_d;     // Next state
  logic [15:0]         count_q;  // Elements done in block
  logic [15:0]         count_d;  // Next count
  logic                bsel_q;   // Buffer B active
  logic                bsel_d;   // Next buffer select
  logic                trig_q;   // Pending element request
  logic                trig_d;   // Next pending request

  // Bus master next values
  logic        ram_req_d;
  logic        ram_we_d;
  logic [15:0] ram_addr_d;
  logic [1:0]  ram_be_d;
  logic [15:0] ram_wdata_d;
  logic        per_req_d;
  logic        per_we_d;
  logic [15:0] per_addr_d;
  logic [1:0]  per_be_d;
  logic [15:0] per_wdata_d;

  // Register bus signals
  logic        acc;      // Access phase
  logic        cap;      // First access cycle, answer prepared
  logic        wr_en;    // Completing write edge
  logic        hit;      // Mapped address
  logic [31:0] rd_mux;   // Read data
  localparam int ST_W_C = dcc_pkg::ST_W; // Status width
  logic [ST_W_C-1:0] st_bits; // Busy and buffer flags
  logic [ST_W_C-1:0] irq_stat;
  logic [ST_W_C-1:0] irq_mask;
  logic [ST_W_C-1:0] evt;
  logic [ST_W_C-1:0] clr;

  // Control fields
  logic       channel_on; // Channel on
  logic       byte_sz;   // Byte elements
  logic       dir;       // RAM to peripheral
  logic       half;      // Half-block interrupt
  logic       dummy;     // Dummy peripheral write
  logic [1:0] apat;      // Address pattern
  logic       once;      // One-shot
  logic       pp;        // Ping-pong

  // Datapath and sequencing wires
  logic        go;       // Start an element
  logic        src_ack;  // Source answered
  logic [15:0] src_raw;  // Raw source data
  logic        src_a0;   // Source byte address bit
  logic [7:0]  lane;     // Selected byte
  logic [15:0] wdata;    // Element data to write
  logic [15:0] dst_addr; // RAM address of this element
  logic        wr_done;  // All writes answered
  logic        blk_end;  // Last element of block
  logic        at_half;  // Midpoint element
  logic        stop;     // Run finishes here
  logic        arm;      // Software turns channel on

  dcc_agen_if ag ();

  assign channel_on = ctrl_q[dcc_pkg::B_ON];
  assign byte_sz = ctrl_q[dcc_pkg::B_SIZE];
  assign dir     = ctrl_q[dcc_pkg::B_DIR];
  assign half    = ctrl_q[dcc_pkg::B_HALF];
  assign dummy   = ctrl_q[dcc_pkg::B_DUMMY];
  assign apat    = ctrl_q[dcc_pkg::B_APAT +: 2];
  assign once    = ctrl_q[dcc_pkg::B_ONCE];
  assign pp      = ctrl_q[dcc_pkg::B_PP];

  // Register bus decode: one wait state, write at completing edge
  assign acc   = psel & penable;
  assign cap   = acc & ~pready;
  assign wr_en = acc & pready & pwrite & hit;
  assign hit   = (paddr == dcc_pkg::OFF_CTRL)   ||
                 (paddr == dcc_pkg::OFF_BUF_A)  ||
                 (paddr == dcc_pkg::OFF_BUF_B)  ||
                 (paddr == dcc_pkg::OFF_PERIPH) ||
                 (paddr == dcc_pkg::OFF_LEN)    ||
                 (paddr == dcc_pkg::OFF_STAT)   ||
                 (paddr == dcc_pkg::OFF_MASK)   ||
                 (paddr == dcc_pkg::OFF_STATE);
  assign st_bits = {bsel_q, st_q != dcc_pkg::S_IDLE};
  assign rd_mux =
    (paddr == dcc_pkg::OFF_CTRL)   ? {16'h0000, ctrl_q} :
    (paddr == dcc_pkg::OFF_BUF_A)  ? {16'h0000, buf_a_q} :
    (paddr == dcc_pkg::OFF_BUF_B)  ? {16'h0000, buf_b_q} :
    (paddr == dcc_pkg::OFF_PERIPH) ? {16'h0000, periph_q} :
    (paddr == dcc_pkg::OFF_LEN)    ? {16'h0000, len_q} :
    (paddr == dcc_pkg::OFF_STAT)   ? {30'h00000000, irq_stat} :
    (paddr == dcc_pkg::OFF_MASK)   ? {30'h00000000, irq_mask} :
    (paddr == dcc_pkg::OFF_STATE)  ? {count_q, 14'h0000, st_bits} :
    32'h00000000;
  assign clr = (wr_en && paddr == dcc_pkg::OFF_STAT) ?
               pwdata[ST_W_C-1:0] : '0;

  // Control word: software write masks unbuilt bits, stop clears on
  assign arm    = wr_en && paddr == dcc_pkg::OFF_CTRL &&
                  pwdata[dcc_pkg::B_ON] && !channel_on;
  assign ctrl_d = (wr_en && paddr == dcc_pkg::OFF_CTRL) ?
                  (pwdata[15:0] & dcc_pkg::CTRL_MASK) :
                  stop ? (ctrl_q & ~(16'h0001 << dcc_pkg::B_ON)) :
                  ctrl_q;

  // Element sequencing
  assign go      = channel_on && trig_q && st_q == dcc_pkg::S_IDLE;
  assign src_ack = dir ? ram_ack : per_ack;
  assign src_raw = dir ? ram_rdata : per_rdata;
  assign src_a0  = dir ? ram_addr[0] : per_addr[0];
  assign lane    = src_a0 ? src_raw[15:8] : src_raw[7:0];
  assign wdata   = byte_sz ? {lane, lane} : src_raw;
  assign dst_addr = ag.addr;
  assign wr_done = (!ram_req || ram_ack) && (!per_req || per_ack);
  assign blk_end = count_q == len_q;
  assign at_half = count_q == (len_q >> 1);
  assign stop    = st_q == dcc_pkg::S_NEXT && blk_end && once &&
                   (!pp || bsel_q);
  // Interrupt point follows the half bit
  assign evt[dcc_pkg::ST_BLK]  = st_q == dcc_pkg::S_NEXT &&
                                 (half ? at_half : blk_end);
  assign evt[dcc_pkg::ST_STOP] = stop;

  // Address generator hookup
  assign ag.load    = arm || (st_q == dcc_pkg::S_NEXT && blk_end);
  assign ag.step    = st_q == dcc_pkg::S_NEXT;
  assign ag.byte_sz = byte_sz;
  assign ag.pattern = apat;
  assign ag.base    = bsel_q ? buf_b_q : buf_a_q;
  assign ag.index   = per_index;

  // Byte lane enables for a 16-bit bus
  function automatic logic [1:0] lanes(input logic bsz, input logic a0);
    lanes = bsz ? (a0 ? 2'b10 : 2'b01) : 2'b11;
  endfunction : lanes

  // Next state, counters and bus requests
  always_comb
  begin
    st_d        = st_q;
    count_d     = arm ? 16'h0000 : count_q;
    bsel_d      = arm ? 1'b0 : bsel_q;
    trig_d      = trig_q;
    ram_req_d   = ram_req & ~ram_ack;
    ram_we_d    = ram_we;
    ram_addr_d  = ram_addr;
    ram_be_d    = ram_be;
    ram_wdata_d = ram_wdata;
    per_req_d   = per_req & ~per_ack;
    per_we_d    = per_we;
    per_addr_d  = per_addr;
    per_be_d    = per_be;
    per_wdata_d = per_wdata;
    if (go)
      trig_d = 1'b0;
    if (xfer_trig)
      trig_d = 1'b1;
    case (st_q)
      dcc_pkg::S_IDLE:
      begin
        // Read the source element
        if (go)
        begin
          st_d = dcc_pkg::S_RD;
          if (dir)
          begin
            ram_req_d  = 1'b1;
            ram_we_d   = 1'b0;
            ram_addr_d = dst_addr;
            ram_be_d   = lanes(byte_sz, dst_addr[0]);
          end
          else
          begin
            per_req_d  = 1'b1;
            per_we_d   = 1'b0;
            per_addr_d = periph_q;
            per_be_d   = lanes(byte_sz, periph_q[0]);
          end
        end
      end
      dcc_pkg::S_RD:
      begin
        // Source answered: write the destination
        if (src_ack)
        begin
          st_d = dcc_pkg::S_WR;
          if (dir)
          begin
            per_req_d   = 1'b1;
            per_we_d    = 1'b1;
            per_addr_d  = periph_q;
            per_be_d    = lanes(byte_sz, periph_q[0]);
            per_wdata_d = wdata;
          end
          else
          begin
            ram_req_d   = 1'b1;
            ram_we_d    = 1'b1;
            ram_addr_d  = dst_addr;
            ram_be_d    = lanes(byte_sz, dst_addr[0]);
            ram_wdata_d = wdata;
            if (dummy)
            begin
              per_req_d   = 1'b1;
              per_we_d    = 1'b1;
              per_addr_d  = periph_q;
              per_be_d    = lanes(byte_sz, periph_q[0]);
              per_wdata_d = 16'h0000;
            end
          end
        end
      end
      dcc_pkg::S_WR:
      begin
        // Wait for every write to be answered
        if (wr_done)
          st_d = dcc_pkg::S_NEXT;
      end
      dcc_pkg::S_NEXT:
      begin
        // Count element, restart or end the block
        st_d    = dcc_pkg::S_IDLE;
        count_d = blk_end ? 16'h0000 : count_q + 16'h0001;
        if (blk_end && pp)
          bsel_d = ~bsel_q;
      end
      default:
        st_d = dcc_pkg::S_IDLE;
    endcase
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= dcc_pkg::CTRL_RST;
      buf_a_q  <= dcc_pkg::WORD_RST;
      buf_b_q  <= dcc_pkg::WORD_RST;
      periph_q <= dcc_pkg::WORD_RST;
      len_q    <= dcc_pkg::WORD_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      if (wr_en && paddr == dcc_pkg::OFF_BUF_A)
        buf_a_q <= pwdata[15:0];
      if (wr_en && paddr == dcc_pkg::OFF_BUF_B)
        buf_b_q <= pwdata[15:0];
      if (wr_en && paddr == dcc_pkg::OFF_PERIPH)
        periph_q <= pwdata[15:0];
      if (wr_en && paddr == dcc_pkg::OFF_LEN)
        len_q <= pwdata[15:0];
    end
  end

  // Register bus answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= cap;
      pslverr <= cap & ~hit;
      if (cap)
        prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // Engine registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= dcc_pkg::S_IDLE;
      count_q <= 16'h0000;
      bsel_q  <= 1'b0;
      trig_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      count_q <= count_d;
      bsel_q  <= bsel_d;
      trig_q  <= trig_d;
    end
  end

  // Bus master outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_req   <= 1'b0;
      ram_we    <= 1'b0;
      ram_addr  <= 16'h0000;
      ram_be    <= 2'b00;
      ram_wdata <= 16'h0000;
      per_req   <= 1'b0;
      per_we    <= 1'b0;
      per_addr  <= 16'h0000;
      per_be    <= 2'b00;
      per_wdata <= 16'h0000;
    end
    else
    begin
      ram_req   <= ram_req_d;
      ram_we    <= ram_we_d;
      ram_addr  <= ram_addr_d;
      ram_be    <= ram_be_d;
      ram_wdata <= ram_wdata_d;
      per_req   <= per_req_d;
      per_we    <= per_we_d;
      per_addr  <= per_addr_d;
      per_be    <= per_be_d;
      per_wdata <= per_wdata_d;
    end
  end

  // Address generator
  dcc_addr_gen u_agen (
    .pclk    (pclk),
    .presetn (presetn),
    .ag      (ag)
  );

  // Status, mask and interrupt
  dcc_irq #(
    .W (ST_W_C)
  ) u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .evt        (evt),
    .clr        (clr),
    .mask_wr    (wr_en && paddr == dcc_pkg::OFF_MASK),
    .mask_wdata (pwdata[ST_W_C-1:0]),
    .status     (irq_stat),
    .mask       (irq_mask),
    .irq        (irq)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Last element finishing in a given operating mode
  sequence blk_end_s;
    st_q == dcc_pkg::S_NEXT && blk_end;
  endsequence
  sequence cont_s;
    blk_end_s ##0 !once;
  endsequence

  idle_when_off_a: assert property (
    st_q == dcc_pkg::S_IDLE && !channel_on |=> !ram_req && !per_req)
    else $error("transfer started with channel off");
  byte_lanes_a: assert property (
    ram_req |-> (ram_be == 2'b11) == !byte_sz)
    else $error("byte enables disagree with size");
  dir_source_a: assert property (
    st_q == dcc_pkg::S_RD && $rose(ram_req) |-> dir && !ram_we)
    else $error("RAM read in wrong direction");
  half_point_a: assert property (
    st_q == dcc_pkg::S_NEXT && half && count_q == (len_q >> 1) |=>
    irq_stat[dcc_pkg::ST_BLK])
    else $error("half interrupt at wrong element");
  null_write_a: assert property (
    st_q == dcc_pkg::S_RD && src_ack && dummy && !dir |=>
    per_req && per_we && per_wdata == 16'h0000 && ram_req)
    else $error("dummy peripheral write missing");
  cont_restart_a: assert property (
    cont_s |=> channel_on && count_q == 16'h0000 &&
    st_q == dcc_pkg::S_IDLE)
    else $error("continuous mode did not restart");
  pp_toggle_a: assert property (
    blk_end_s ##0 pp |=> bsel_q != $past(bsel_q))
    else $error("ping-pong buffer did not alternate");
  oneshot_stop_a: assert property (
    blk_end_s ##0 once && (!pp || bsel_q) |=> !channel_on)
    else $error("one-shot did not stop");
  unbuilt_zero_a: assert property (
    (ctrl_q & ~dcc_pkg::CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bits set");

endmodule : dcc_top

// ### core/dcc_pkg.sv
// Shared constants and types of the channel control block
package dcc_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0] OFF_CTRL   = 8'h00; // Control word
  localparam logic [7:0] OFF_BUF_A  = 8'h04; // Buffer A start
  localparam logic [7:0] OFF_BUF_B  = 8'h08; // Buffer B start
  localparam logic [7:0] OFF_PERIPH = 8'h0C; // Peripheral data address
  localparam logic [7:0] OFF_LEN    = 8'h10; // Elements per block minus 1
  localparam logic [7:0] OFF_STAT   = 8'h14; // Sticky event status
  localparam logic [7:0] OFF_MASK   = 8'h18; // Interrupt mask
  localparam logic [7:0] OFF_STATE  = 8'h1C; // Live engine state

  // Control word field positions
  localparam int B_ON    = 15; // Channel on
  localparam int B_SIZE  = 14; // Byte when one
  localparam int B_DIR   = 13; // RAM to peripheral when one
  localparam int B_HALF  = 12; // Interrupt at half block
  localparam int B_DUMMY = 11; // Dummy peripheral write
  localparam int B_APAT  = 4;  // Low bit of address pattern
  localparam int B_ONCE  = 0;  // One-shot when one
  localparam int B_PP    = 1;  // Ping-pong when one

  // Implemented bits of the control word and reset values
  localparam logic [15:0] CTRL_MASK = 16'hF833;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  // Status bit positions
  localparam int ST_BLK  = 0; // Block or half-block event
  localparam int ST_STOP = 1; // One-shot run finished
  localparam int ST_W    = 2; // Number of status bits

  // Addressing patterns
  typedef enum logic [1:0] {
    AP_INC = 2'b00,
    AP_FIX = 2'b01,
    AP_PIA = 2'b10,
    AP_RSV = 2'b11
  } dcc_apat_t;

  // Engine states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RD   = 2'b01,
    S_WR   = 2'b10,
    S_NEXT = 2'b11
  } dcc_state_t;

endpackage : dcc_pkg

// ### core/dcc_agen_if.sv
`timescale 1ns/1ps
// Link between engine and RAM address generator
interface dcc_agen_if;
  logic        load;    // Restart offset at zero
  logic        step;    // Element finished
  logic        byte_sz; // Byte elements
  logic [1:0]  pattern; // Addressing pattern
  logic [15:0] base;    // Active buffer start
  logic [15:0] index;   // Offset given by peripheral
  logic [15:0] addr;    // Current RAM address

  // Engine side
  modport ctl (output load, step, byte_sz, pattern, base, index,
               input addr);
  // Generator side
  modport gen (input load, step, byte_sz, pattern, base, index,
               output addr);
endinterface : dcc_agen_if

// ### core/dcc_addr_gen.sv
`timescale 1ns/1ps
// RAM address generator for one channel
module dcc_addr_gen (
  input wire logic pclk,
  input wire logic presetn,
  dcc_agen_if.gen  ag
);

  logic [15:0] off_q; // Post-increment offset
  logic [15:0] off_d; // Next offset
  logic [15:0] inc;   // Step per element

  assign inc   = ag.byte_sz ? 16'h0001 : 16'h0002;
  // Only the post-increment pattern advances
  assign off_d = ag.load ? 16'h0000 :
                 (ag.step && ag.pattern == dcc_pkg::AP_INC) ?
                 off_q + inc : off_q;
  // Peripheral indirect takes its offset from the peripheral
  assign ag.addr = ag.base + ((ag.pattern == dcc_pkg::AP_PIA) ?
                   ag.index : off_q);

  // Offset register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      off_q <= 16'h0000;
    else
      off_q <= off_d;
  end

  post_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    ag.step && !ag.load && ag.pattern == dcc_pkg::AP_INC |=>
    off_q == $past(off_q) + (ag.byte_sz ? 16'h0001 : 16'h0002))
    else $error("offset did not advance by element size");

  fixed_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ag.load && ag.pattern == dcc_pkg::AP_FIX |=> $stable(off_q))
    else $error("offset moved without post-increment");

endmodule : dcc_addr_gen

// ### core/dcc_irq.sv
`timescale 1ns/1ps
// Sticky event status, mask and interrupt line
module dcc_irq #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] evt,
  input  wire logic [W-1:0] clr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] mask_wdata,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);

  logic [W-1:0] stat_d; // Next status
  logic [W-1:0] mask_d; // Next mask

  // A set in the clearing cycle survives
  assign stat_d = (status & ~clr) | evt;
  assign mask_d = mask_wr ? mask_wdata : mask;

  // Status, mask and registered interrupt level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      mask   <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      status <= stat_d;
      mask   <= mask_d;
      irq    <= |(stat_d & mask_d);
    end
  end

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    |evt |=> (status & $past(evt)) == $past(evt))
    else $error("event lost in status");

endmodule : dcc_irq

// ### bench/dcc_partner.sv
`timescale 1ns/1ps
// RAM and peripheral data register on the far side of the channel
module dcc_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        ram_req,
  input  wire logic [15:0] ram_addr,
  output logic      [15:0] ram_rdata,
  output logic             ram_ack,
  input  wire logic        per_req,
  input  wire logic        per_we,
  output logic      [15:0] per_rdata,
  output logic             per_ack
);
  logic [15:0] t_q; // Free count, also idle bus noise
  logic [15:0] n_q; // Peripheral reads answered
  logic        ra;  // RAM answers this edge
  logic        pa;  // Peripheral answers this edge

  // Slow mode answers only on some cycles
  assign ra = ram_req && !ram_ack && (!slow || t_q[0]);
  assign pa = per_req && !per_ack && (!slow || t_q[1]);

  // One-cycle answers; read lines change every cycle when idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t_q       <= 16'h0000;
      n_q       <= 16'h0000;
      ram_ack   <= 1'b0;
      per_ack   <= 1'b0;
      ram_rdata <= 16'h0000;
      per_rdata <= 16'h0000;
    end
    else
    begin
      t_q       <= t_q + 16'h0001;
      ram_ack   <= ra;
      per_ack   <= pa;
      ram_rdata <= ra ? ~ram_addr : t_q;
      per_rdata <= (pa && !per_we) ? 16'h1200 + n_q : ~t_q;
      if (pa && !per_we)
        n_q <= n_q + 16'h0001;
    end
  end
endmodule : dcc_partner

// ### bench/testbench.sv
`timescale 1ns/1ps
// Self-checking bench of the channel control block
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        xfer_trig, slow, e, irq;
  logic [15:0] per_index, ram_addr, ram_wdata, ram_rdata;
  logic [15:0] per_addr, per_wdata, per_rdata;
  logic        ram_req, ram_we, ram_ack, per_req, per_we, per_ack;
  logic [1:0]  ram_be, per_be;
  logic [33:0] rq[$]; // RAM writes seen
  logic [33:0] pq[$]; // Peripheral writes seen
  int          err_count, total_checks, seed, pv;
  localparam logic [15:0] BA = 16'h0040;
  localparam logic [15:0] BB = 16'h0100;
  localparam logic [15:0] PA = 16'h0010;

  dcc_top     u_dcc_top (.*);
  dcc_partner u_dcc_partner (.*);

  // Clock of 4 ns
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Record every answered write
  always @(posedge pclk)
  begin
    if (ram_req === 1'b1 && ram_ack === 1'b1 && ram_we === 1'b1)
      rq.push_back({ram_addr, ram_be, ram_wdata});
    if (per_req === 1'b1 && per_ack === 1'b1 && per_we === 1'b1)
      pq.push_back({per_addr, per_be, per_wdata});
  end

  // Compare and count
  task automatic chk(input string n, input logic [35:0] s, x);
    total_checks++;
    if (s !== x)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // Verdict and end of run
  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 40);
    r = prdata;
    e = pslverr;
    if (k >= 40)
      chk("pready", 1'b0, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register read compared with the expected word
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", {e, r}, {1'b0, x});
  endtask : rd

  // Reset held for six cycles
  task automatic rst;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rq.delete();
    pq.delete();
  endtask : rst

  // One element request
  task automatic pulse;
    @(posedge pclk);
    xfer_trig <= 1'b1;
    @(posedge pclk);
    xfer_trig <= 1'b0;
  endtask : pulse

  // Wait, bounded, for writes to be seen
  task automatic wq(input int nr, np);
    for (int k = 0; k < 60 && (rq.size() < nr || pq.size() < np); k++)
      @(posedge pclk);
  endtask : wq

  // Configure, run n elements and compare with the model
  task automatic run(input logic [15:0] c, input int len, n);
    int          tot, i, b, h, d;
    logic [15:0] a, v, dd;
    logic [7:0]  y;
    logic [1:0]  be, mk, pb;
    rst();
    pv = 0;
    slow <= $random(seed);
    per_index <= $random(seed) & 16'h00FE;
    mk = $random(seed);
    apb(1'b1, dcc_pkg::OFF_BUF_A, {16'h0, BA});
    apb(1'b1, dcc_pkg::OFF_BUF_B, {16'h0, BB});
    apb(1'b1, dcc_pkg::OFF_PERIPH, {16'h0, PA});
    apb(1'b1, dcc_pkg::OFF_LEN, len);
    apb(1'b1, dcc_pkg::OFF_MASK, {30'h0, mk});
    apb(1'b1, dcc_pkg::OFF_CTRL, {16'h0, c});
    pulse();
    repeat (20) @(posedge pclk);
    chk("off", {ram_req, per_req, 8'(rq.size() + pq.size())}, 0);
    apb(1'b1, dcc_pkg::OFF_CTRL, {16'h0, c | 16'h8000});
    tot = c[0] ? (len + 1) * (c[1] ? 2 : 1) : 9999;
    for (d = 0; d < n; d++)
    begin
      if (d > 0)
        pulse();
      i = d % (len + 1);
      b = (c[1] && (d / (len + 1)) % 2 == 1) ? BB : BA;
      a = c[5] ? b + per_index : c[4] ? b : b + i * (c[14] ? 1 : 2);
      v = c[13] ? ~a : 16'h1200 + pv;
      y = (c[13] && a[0]) ? v[15:8] : v[7:0];
      dd = c[14] ? {y, y} : v;
      be = c[14] ? (a[0] ? 2'b10 : 2'b01) : 2'b11;
      // Peripheral address is even, so a byte uses the low lane
      pb = c[14] ? 2'b01 : 2'b11;
      if (d >= tot)
      begin
        repeat (30) @(posedge pclk);
        chk("stopped", rq.size() + pq.size(), 0);
      end
      else if (c[13])
      begin
        wq(0, 1);
        chk("per write", pq.pop_front(), {PA, pb, dd});
      end
      else
      begin
        wq(1, c[11]);
        pv++;
        chk("ram write", rq.pop_front(), {a, be, dd});
        if (c[11])
          chk("null write", pq.pop_front(), {PA, pb, 16'h0000});
      end
    end
    h = c[12] ? len >> 1 : len;
    d = (n < tot) ? n : tot;
    v = {c[0] && d == tot, d > h};
    rd(dcc_pkg::OFF_STAT, {16'h0, v});
    chk("irq", irq, |(v[1:0] & mk));
    rd(dcc_pkg::OFF_CTRL, d == tot ? c : c | 16'h8000);
    apb(1'b1, dcc_pkg::OFF_STAT, 32'h3);
    rd(dcc_pkg::OFF_STAT, 32'h0);
    chk("irq clear", irq, 1'b0);
  endtask : run

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, xfer_trig, slow} = 6'h00;
    {paddr, pwdata, per_index} = 56'h0;
    {err_count, total_checks, pv} = 0;
    seed = 32'h2569829A;
    rst();
    for (int k = 0; k < 8; k++)
      rd(8'(k * 4), 32'h0);
    apb(1'b1, dcc_pkg::OFF_CTRL, 32'hFFFF07CC);
    rd(dcc_pkg::OFF_CTRL, 32'h0);
    pv = $random(seed) & 32'h7FFF7FDF;
    apb(1'b1, dcc_pkg::OFF_CTRL, pv);
    rd(dcc_pkg::OFF_CTRL, pv & dcc_pkg::CTRL_MASK);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", {e, r}, {1'b1, 32'h0});
    // Address pattern 11 is never programmed
    run(16'h0000, 3, 6);
    run(16'h5801, 3, 5);
    run(16'h2012, 1, 5);
    run(16'h6023, 1, 5);
    run(16'h0822, 2, 7);
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    tally_and_finish();
  end
endmodule : testbench
